// ### inc/mpm_params.svh
`ifndef MPM_PARAMS_SVH
`define MPM_PARAMS_SVH
`define MPM_CLK_HZ 25000000
`define MPM_SEG_MS 1000
`define MPM_HOLD_MS 1000
`define MPM_FAST_MS 2000
`define MPM_SLOW_REP_MS 200
`define MPM_FAST_REP_MS 50
`define MPM_EDIT_TO_MS 10000
`define MPM_MENU_TO_MS 60000
`define MPM_OPEN_MS 2000
`define MPM_RECALL_MS 2000
`define MPM_LABEL_MS 500
`define MPM_CLR_MS 2000
`define MPM_B1 0
`define MPM_B2 1
`define MPM_B3 2
`define MPM_B4 3
`define MPM_B5 4
`define MPM_REG_CTRL 5'h00
`define MPM_REG_SCLO 5'h04
`define MPM_REG_OFFSET_ITEM 5'h08
`define MPM_REG_SLOPE 5'h0C
`define MPM_REG_MIN 5'h10
`define MPM_REG_MAX 5'h14
`define MPM_REG_STAT 5'h18
`define MPM_OFF_MIN 16'shF831
`define MPM_OFF_MAX 16'sh270F
`define MPM_SLOPE_MIN 16'shD8F1
`define MPM_SLOPE_MAX 16'sh270F
`define MPM_SLOPE_ONE 17'sh02710
`define MPM_SLOPE_DIV 35'sh2710
`define MPM_DISP_MAX 36'sh0270F
`define MPM_DISP_MIN 36'shFFFFFF831
`endif

// ### inc/mpm_pkg.sv
package mpm_pkg;
  typedef enum logic [1:0] {MS_CLOSED, MS_VIEW, MS_EDIT} mpm_menu_t;
  typedef enum logic [2:0] {RC_IDLE, RC_LOW_LBL, RC_LOW_VAL, RC_HIGH_LBL, RC_HIGH_VAL, RC_CLR_LBL} mpm_recall_t;
  typedef enum logic [3:0] {SH_SEG, SH_MEAS, SH_ITEM_OFFSET_ITEM, SH_ITEM_SLOPE, SH_EDIT, SH_LOW_LBL,
    SH_HIGH_LBL, SH_CLR_LBL, SH_MIN, SH_MAX, SH_CODE} mpm_show_t;
  typedef enum logic [3:0] {EC_NONE, EC_OVER_RANGE, EC_UNDER_RANGE, EC_DISP_OVER, EC_DISP_UNDER,
    EC_SYSTEM, EC_SENSOR, EC_UNCOMPUTABLE, EC_INVALID_CONFIG, EC_INCOMPLETE} mpm_code_t;
  typedef struct packed {
    logic valid;
    logic signed [15:0] value;
    logic overRange;
    logic underRange;
    logic sensorFault;
    logic selfDiagFail;
    logic uncomputable;
    logic invalidConfig;
    logic incompleteConfig;
    logic lowAlarm;
    logic highAlarm;
    logic sysAlarm;
  } mpm_meas_t;
  typedef struct packed {
    mpm_show_t show;
    mpm_code_t code;
    logic signed [15:0] value;
  } mpm_disp_t;
  typedef struct packed {
    logic alarm;
    logic min;
    logic max;
  } mpm_led_t;
endpackage

// ### rtl/mpm_panel.sv
`include "mpm_params.svh"
module mpm_panel
  import mpm_pkg::*;
#(
  parameter logic [19:0] MS_CYCLES = 20'(`MPM_CLK_HZ / 1000),
  parameter logic [16:0] SEG_MS = `MPM_SEG_MS,
  parameter logic [16:0] HOLD_MS = `MPM_HOLD_MS,
  parameter logic [16:0] FAST_MS = `MPM_FAST_MS,
  parameter logic [7:0] SLOW_REP_MS = `MPM_SLOW_REP_MS,
  parameter logic [7:0] FAST_REP_MS = `MPM_FAST_REP_MS,
  parameter logic [16:0] EDIT_TO_MS = `MPM_EDIT_TO_MS,
  parameter logic [16:0] MENU_TO_MS = `MPM_MENU_TO_MS,
  parameter logic [16:0] OPEN_MS = `MPM_OPEN_MS,
  parameter logic [16:0] RECALL_MS = `MPM_RECALL_MS,
  parameter logic [16:0] LABEL_MS = `MPM_LABEL_MS,
  parameter logic [16:0] CLR_MS = `MPM_CLR_MS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [4:0] btnRaw,
  input wire mpm_meas_t meas,
  output mpm_disp_t disp,
  output mpm_led_t led
);
  localparam logic [4:0] B2M = 5'h02;
  localparam logic [4:0] B3M = 5'h04;
  localparam logic [4:0] B5M = 5'h10;

  logic [4:0] btnS1, btnS2, btnS3, btnState, btnPrev, press;
  logic [19:0] msCnt;
  logic msTick;
  logic [16:0] holdMs, idleMs, segMs, rcMs;
  logic segDone;
  mpm_menu_t menuState;
  mpm_recall_t rcState;
  logic item;
  logic signed [15:0] editVal, offsetVal, slopeVal, scaleLo, curVal, minVal, maxVal;
  logic [7:0] repMs;
  logic ctrlTemp, ctrlFn, ctrlNoSlope, mmValid;
  logic [3:0] inputMode;
  mpm_code_t curCode, nextCode;
  mpm_disp_t next_disp;
  logic [31:0] rdData;

  // three-stage sync; a bit moves only when stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      btnS1 <= '0;
      btnS2 <= '0;
      btnS3 <= '0;
      btnState <= '0;
      btnPrev <= '0;
    end else if (clkEn) begin
      btnS1 <= btnRaw;
      btnS2 <= btnS1;
      btnS3 <= btnS2;
      btnState <= (btnS2 & btnS3) | (btnState & (btnS2 | btnS3));
      btnPrev <= btnState;
    end
  end
  assign press = btnState & ~btnPrev;

  assign msTick = (msCnt == MS_CYCLES - 20'h00001);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) msCnt <= '0;
    else if (clkEn) msCnt <= msTick ? '0 : msCnt + 20'h00001;
  end

  // hold time of the current button combination, idle time since release
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      holdMs <= '0;
      idleMs <= '0;
    end else if (clkEn) begin
      if (btnState != btnPrev || btnState == '0) holdMs <= '0;
      else if (msTick && holdMs != '1) holdMs <= holdMs + 17'h00001;
      if (btnState != '0) idleMs <= '0;
      else if (msTick && idleMs != '1) idleMs <= idleMs + 17'h00001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      segMs <= '0;
      segDone <= 1'b0;
    end else if (clkEn && !segDone && msTick) begin
      segMs <= segMs + 17'h00001;
      segDone <= (segMs >= SEG_MS - 17'h00001);
    end
  end

  // menu control
  logic menuTo, editTo, openReq, slopeAvail, rolling, repDue, commit;
  logic signed [15:0] itemLo, itemHi;
  assign menuTo = (idleMs > MENU_TO_MS);
  assign editTo = (idleMs > EDIT_TO_MS);
  assign openReq = segDone && btnState == (B5M | B3M) && msTick && holdMs == OPEN_MS;
  assign slopeAvail = !ctrlNoSlope;
  assign itemLo = item ? `MPM_SLOPE_MIN : `MPM_OFF_MIN;
  assign itemHi = item ? `MPM_SLOPE_MAX : `MPM_OFF_MAX;
  assign rolling = menuState == MS_EDIT && (btnState == B2M || btnState == B3M) && holdMs >= HOLD_MS;
  assign repDue = rolling && msTick
    && repMs >= ((holdMs >= HOLD_MS + FAST_MS) ? FAST_REP_MS : SLOW_REP_MS) - 8'h01;
  assign commit = menuState == MS_EDIT && press[`MPM_B1] && !menuTo;

  function automatic logic signed [15:0] stepVal(input logic signed [15:0] v, input logic up,
                                                 input logic signed [15:0] lo, input logic signed [15:0] hi);
    if (up) return (v >= hi) ? lo : v + 16'sh0001;
    return (v <= lo) ? hi : v - 16'sh0001;
  endfunction

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) repMs <= '0;
    else if (clkEn) begin
      if (!rolling) repMs <= '0;
      else if (msTick) repMs <= repDue ? '0 : repMs + 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      menuState <= MS_CLOSED;
      item <= 1'b0;
      editVal <= '0;
    end else if (clkEn) begin
      case (menuState)
        MS_CLOSED: begin
          if (openReq) begin
            menuState <= MS_VIEW;
            item <= 1'b0;
          end
        end
        MS_VIEW: begin
          if (menuTo || press[`MPM_B4]) menuState <= MS_CLOSED;
          else if (press[`MPM_B1]) item <= slopeAvail ? ~item : 1'b0;
          else if (press[`MPM_B2] || press[`MPM_B3]) begin
            menuState <= MS_EDIT;
            editVal <= item ? slopeVal : offsetVal;
          end
        end
        MS_EDIT: begin
          if (menuTo) menuState <= MS_CLOSED;
          else if (press[`MPM_B1] || press[`MPM_B4] || editTo) menuState <= MS_VIEW;
          else if (press[`MPM_B2] || (repDue && btnState[`MPM_B2])) editVal <= stepVal(editVal, 1'b1, itemLo, itemHi);
          else if (press[`MPM_B3] || (repDue && btnState[`MPM_B3])) editVal <= stepVal(editVal, 1'b0, itemLo, itemHi);
        end
        default: menuState <= MS_CLOSED;
      endcase
    end
  end

  // register bus; one wait state, ack drops the cycle after it rose
  logic wbReq, wbWr, modeChg;
  assign wbReq = cyc_i && stb_i && !ack_o;
  assign wbWr = wbReq && we_i;
  assign modeChg = wbWr && adr_i == `MPM_REG_CTRL && sel_i[0] && dat_i[7:4] != inputMode;

  function automatic logic [15:0] merge(input logic [15:0] o, input logic [31:0] d, input logic [3:0] s);
    return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else if (clkEn) begin
      ack_o <= wbReq;
      if (wbReq) dat_o <= we_i ? 32'h00000000 : rdData;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrlTemp <= 1'b0;
      ctrlFn <= 1'b0;
      ctrlNoSlope <= 1'b0;
      inputMode <= '0;
      scaleLo <= '0;
    end else if (clkEn && wbWr) begin
      if (adr_i == `MPM_REG_CTRL && sel_i[0]) begin
        ctrlTemp <= dat_i[0];
        ctrlFn <= dat_i[1];
        ctrlNoSlope <= dat_i[2];
        inputMode <= dat_i[7:4];
      end
      if (adr_i == `MPM_REG_SCLO) scaleLo <= merge(scaleLo, dat_i, sel_i);
    end
  end

  // mode change wins over a commit; a commit wins over a bus write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      offsetVal <= '0;
      slopeVal <= '0;
    end else if (clkEn) begin
      if (modeChg) begin
        offsetVal <= '0;
        slopeVal <= '0;
      end else if (commit) begin
        if (item) slopeVal <= editVal;
        else offsetVal <= editVal;
      end else if (wbWr && adr_i == `MPM_REG_OFFSET_ITEM) offsetVal <= merge(offsetVal, dat_i, sel_i);
      else if (wbWr && adr_i == `MPM_REG_SLOPE) slopeVal <= merge(slopeVal, dat_i, sel_i);
    end
  end

  always_comb begin
    rdData = '0;
    case (adr_i)
      `MPM_REG_CTRL: rdData[7:0] = {inputMode, 1'b0, ctrlNoSlope, ctrlFn, ctrlTemp};
      `MPM_REG_SCLO: rdData[15:0] = scaleLo;
      `MPM_REG_OFFSET_ITEM: rdData[15:0] = offsetVal;
      `MPM_REG_SLOPE: rdData[15:0] = slopeVal;
      `MPM_REG_MIN: rdData[15:0] = minVal;
      `MPM_REG_MAX: rdData[15:0] = maxVal;
      `MPM_REG_STAT: rdData[11:0] = {mmValid, segDone, item, menuState, rcState, curCode};
      default: rdData = '0;
    endcase
  end

  // correction; the divide is wide but only sees a new sample now and then
  logic signed [17:0] diff;
  logic signed [16:0] factor;
  logic signed [34:0] prod, quo;
  logic signed [35:0] res;
  always_comb begin
    diff = 18'($signed(meas.value)) - 18'(offsetVal) - (ctrlTemp ? 18'sh00000 : 18'(scaleLo));
    factor = `MPM_SLOPE_ONE + 17'(slopeVal);
    prod = 35'(diff) * 35'(factor);
    quo = prod / `MPM_SLOPE_DIV;
    res = 36'(quo) + (ctrlTemp ? 36'sh000000000 : 36'(scaleLo));
  end

  always_comb begin
    if (meas.selfDiagFail) nextCode = EC_SYSTEM;
    else if (meas.sensorFault) nextCode = EC_SENSOR;
    else if (meas.incompleteConfig) nextCode = EC_INCOMPLETE;
    else if (meas.invalidConfig) nextCode = EC_INVALID_CONFIG;
    else if (meas.uncomputable) nextCode = EC_UNCOMPUTABLE;
    else if (meas.overRange) nextCode = EC_OVER_RANGE;
    else if (meas.underRange) nextCode = EC_UNDER_RANGE;
    else if (res > `MPM_DISP_MAX) nextCode = EC_DISP_OVER;
    else if (res < `MPM_DISP_MIN) nextCode = EC_DISP_UNDER;
    else nextCode = EC_NONE;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      curVal <= '0;
      curCode <= EC_NONE;
    end else if (clkEn && meas.valid) begin
      curCode <= nextCode;
      if (nextCode == EC_NONE) curVal <= res[15:0];
    end
  end

  // recall and clear only while the menu is shut
  logic idleOk, lowReq, highReq, clrReq, rcDone;
  assign idleOk = segDone && menuState == MS_CLOSED && btnState == '0 && holdMs < HOLD_MS;
  assign lowReq = idleOk && btnPrev == B3M;
  assign highReq = idleOk && btnPrev == B2M;
  assign clrReq = segDone && menuState == MS_CLOSED && btnState == (B2M | B3M) && msTick && holdMs == CLR_MS;
  assign rcDone = msTick && rcMs >= ((rcState == RC_LOW_VAL || rcState == RC_HIGH_VAL) ? RECALL_MS : LABEL_MS)
    - 17'h00001;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rcState <= RC_IDLE;
      rcMs <= '0;
    end else if (clkEn) begin
      if (rcState == RC_IDLE || rcDone) rcMs <= '0;
      else if (msTick) rcMs <= rcMs + 17'h00001;
      case (rcState)
        RC_IDLE: begin
          if (clrReq) rcState <= RC_CLR_LBL;
          else if (lowReq) rcState <= RC_LOW_LBL;
          else if (highReq) rcState <= RC_HIGH_LBL;
        end
        RC_LOW_LBL: if (rcDone) rcState <= RC_LOW_VAL;
        RC_HIGH_LBL: if (rcDone) rcState <= RC_HIGH_VAL;
        RC_LOW_VAL, RC_HIGH_VAL, RC_CLR_LBL: if (rcDone) rcState <= RC_IDLE;
        default: rcState <= RC_IDLE;
      endcase
      if (menuState != MS_CLOSED) rcState <= RC_IDLE;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mmValid <= 1'b0;
      minVal <= '0;
      maxVal <= '0;
    end else if (clkEn) begin
      if (rcState == RC_CLR_LBL && rcDone) begin
        mmValid <= 1'b1;
        minVal <= curVal;
        maxVal <= curVal;
      end else if (meas.valid && nextCode == EC_NONE) begin
        mmValid <= 1'b1;
        if (!mmValid || $signed(res[15:0]) < minVal) minVal <= res[15:0];
        if (!mmValid || $signed(res[15:0]) > maxVal) maxVal <= res[15:0];
      end
    end
  end

  always_comb begin
    next_disp = '{show: SH_MEAS, code: curCode, value: curVal};
    if (!segDone) next_disp.show = SH_SEG;
    else if (menuState == MS_VIEW) next_disp.show = item ? SH_ITEM_SLOPE : SH_ITEM_OFFSET_ITEM;
    else if (menuState == MS_EDIT) begin
      next_disp.show = SH_EDIT;
      next_disp.value = editVal;
    end else begin
      case (rcState)
        RC_LOW_LBL: next_disp.show = SH_LOW_LBL;
        RC_HIGH_LBL: next_disp.show = SH_HIGH_LBL;
        RC_CLR_LBL: next_disp.show = SH_CLR_LBL;
        RC_LOW_VAL: begin
          next_disp.show = SH_MIN;
          next_disp.value = minVal;
        end
        RC_HIGH_VAL: begin
          next_disp.show = SH_MAX;
          next_disp.value = maxVal;
        end
        default: if (curCode != EC_NONE) next_disp.show = SH_CODE;
      endcase
    end
  end

  logic sysErr;
  assign sysErr = meas.sysAlarm || meas.selfDiagFail;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      disp <= '{show: SH_SEG, code: EC_NONE, value: 16'sh0000};
      led <= '0;
    end else if (clkEn) begin
      disp <= next_disp;
      led.alarm <= ctrlFn && (meas.lowAlarm || meas.highAlarm || sysErr);
      led.min <= ctrlFn && (meas.lowAlarm || sysErr);
      led.max <= ctrlFn && (meas.highAlarm || sysErr);
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_commit_save: assert property (clkEn && commit && !modeChg |=> menuState == MS_VIEW
    && (item ? slopeVal : offsetVal) == $past(editVal)) else $error("commit did not store value");
  chk_enter_edit: assert property (clkEn && menuState == MS_VIEW && !menuTo && !press[`MPM_B1]
    && !press[`MPM_B4] && (press[`MPM_B2] || press[`MPM_B3]) |=> menuState == MS_EDIT)
    else $error("edit not entered");
  chk_step_up: assert property (clkEn && menuState == MS_EDIT && !menuTo && !editTo && press == B2M
    && editVal != itemHi |=> editVal == $past(editVal) + 16'sh0001) else $error("step up wrong");
  chk_wrap_down: assert property (clkEn && menuState == MS_EDIT && !menuTo && !editTo && press == B3M
    && editVal == itemLo |=> editVal == $past(itemHi)) else $error("wrap below low failed");
  chk_roll_rate: assert property (clkEn && repDue && btnState == B2M && !menuTo && !editTo
    |-> holdMs >= HOLD_MS) else $error("repeat before hold time");
  chk_cancel_keep: assert property (clkEn && menuState == MS_EDIT && press[`MPM_B4] && !menuTo && !modeChg
    ##1 !wbWr |=> menuState == MS_VIEW && offsetVal == $past(offsetVal, 2)) else $error("cancel changed value");
  chk_view_close: assert property (clkEn && menuState == MS_VIEW && press[`MPM_B4]
    |=> menuState == MS_CLOSED) else $error("menu did not close");
  chk_edit_timeout: assert property (clkEn && menuState == MS_EDIT && editTo && !menuTo
    |=> menuState == MS_VIEW) else $error("edit timeout missed");
  chk_mode_reset: assert property (clkEn && modeChg |=> offsetVal == 16'sh0000
    && slopeVal == 16'sh0000) else $error("mode change kept correction");
  chk_sys_leds: assert property (clkEn && ctrlFn && sysErr |=> led.alarm && led.min && led.max)
    else $error("system alarm leds off");
  chk_disp_over: assert property (clkEn && meas.valid && nextCode == EC_DISP_OVER
    |=> curCode == EC_DISP_OVER && res > `MPM_DISP_MAX || !meas.valid) else $error("overflow code lost");
  chk_low_recall: assert property (clkEn && rcState == RC_IDLE && lowReq && !clrReq
    |=> rcState == RC_LOW_LBL ##1 disp.show == SH_LOW_LBL || !clkEn) else $error("low recall missing");
endmodule

// ### sim/mpm_front.sv
module mpm_front
  import mpm_pkg::*;
(
  input wire logic core_clk,
  output logic [4:0] btnRaw,
  output mpm_meas_t meas
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    btnRaw = 5'h00;
    meas = '0;
  end
  // operator holds a chord, lets go, then waits out the debounce
  task automatic push(input logic [4:0] b, input int hold, input int after);
    btnRaw <= b;
    repeat (hold) @(posedge core_clk);
    btnRaw <= 5'h00;
    repeat (after) @(posedge core_clk);
  endtask
  // value scrambled between pulses so a stale value never looks right
  task automatic sample(input logic [15:0] v, input logic [6:0] f);
    meas.valid <= 1'b1;
    meas.value <= v;
    {meas.overRange, meas.underRange, meas.sensorFault, meas.selfDiagFail,
      meas.uncomputable, meas.invalidConfig, meas.incompleteConfig} <= f;
    @(posedge core_clk);
    meas.valid <= 1'b0;
    meas.value <= ~v;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic alarms(input logic [2:0] a);
    {meas.lowAlarm, meas.highAlarm, meas.sysAlarm} <= a;
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// ### sim/mpm_panel_tb_top.sv
`include "mpm_params.svh"
module mpm_panel_tb_top
  import mpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, cyc, stb, we, ack, clkEn;
  logic [4:0] adr, btnRaw;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [15:0] rd;
  mpm_meas_t meas;
  mpm_disp_t disp;
  mpm_led_t led;
  int n_mismatch, n_tests;
  // short millisecond so the timeouts fit in a run
  localparam logic [19:0] TB_MS = 20'h00004;
  localparam logic [16:0] TB_SEG = 17'h00003;
  localparam logic [16:0] TB_HOLD = 17'h0000A;
  localparam logic [16:0] TB_FAST = 17'h0000A;
  localparam logic [7:0] TB_SLOW_REP = 8'h04;
  localparam logic [7:0] TB_FAST_REP = 8'h02;
  localparam logic [16:0] TB_EDIT_TO = 17'h00028;
  localparam logic [16:0] TB_MENU_TO = 17'h00064;
  localparam logic [16:0] TB_OPEN = 17'h00008;
  localparam logic [16:0] TB_RECALL = 17'h00006;
  localparam logic [16:0] TB_LABEL = 17'h00003;
  localparam logic [16:0] TB_CLR = 17'h00008;
  mpm_panel #(.MS_CYCLES(TB_MS), .SEG_MS(TB_SEG), .HOLD_MS(TB_HOLD), .FAST_MS(TB_FAST),
    .SLOW_REP_MS(TB_SLOW_REP), .FAST_REP_MS(TB_FAST_REP), .EDIT_TO_MS(TB_EDIT_TO), .MENU_TO_MS(TB_MENU_TO),
    .OPEN_MS(TB_OPEN), .RECALL_MS(TB_RECALL), .LABEL_MS(TB_LABEL), .CLR_MS(TB_CLR)) u_dut (
    .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .btnRaw(btnRaw),
    .meas(meas), .disp(disp), .led(led));
  mpm_front u_front (.core_clk(core_clk), .btnRaw(btnRaw), .meas(meas));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // classic cycle: hold everything until ack is sampled high
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= {16'h0000, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat[15:0];
    chk("ack", 16'h0001, {15'h0000, ack});
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdc(input string nm, input logic [4:0] a, input logic [15:0] e);
    xfer(1'b0, a, 16'h0000);
    chk(nm, e, rd);
  endtask
  task automatic shows(input mpm_show_t s, input logic [15:0] v);
    chk("show", 16'(s), 16'(disp.show));
    chk("value", v, disp.value);
  endtask
  // code table in flag order: over, under, sensor, self test, uncomputable, invalid, incomplete
  mpm_code_t codes[7] = '{EC_OVER_RANGE, EC_UNDER_RANGE, EC_SENSOR, EC_SYSTEM, EC_UNCOMPUTABLE,
    EC_INVALID_CONFIG, EC_INCOMPLETE};
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    {cyc, stb, we, adr, sel, wdat} = '0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("show", 16'(SH_SEG), 16'(disp.show));
    chk("led", 16'h0000, 16'(led));
    rdc("ctrl", `MPM_REG_CTRL, 16'h0000);
    rdc("unmapped", 5'h1C, 16'h0000);
    repeat (20) @(posedge core_clk);
    $display("test reset done");
    xfer(1'b1, `MPM_REG_CTRL, 16'h0001);
    u_front.sample(16'h01F4, 7'h00);
    u_front.sample(16'hFED4, 7'h00);
    u_front.sample(16'h0320, 7'h00);
    shows(SH_MEAS, 16'h0320);
    rdc("min", `MPM_REG_MIN, 16'hFED4);
    rdc("max", `MPM_REG_MAX, 16'h0320);
    u_front.push(5'h04, 8, 8);
    chk("show", 16'(SH_LOW_LBL), 16'(disp.show));
    repeat (14) @(posedge core_clk);
    shows(SH_MIN, 16'hFED4);
    repeat (40) @(posedge core_clk);
    u_front.push(5'h02, 8, 8);
    chk("show", 16'(SH_HIGH_LBL), 16'(disp.show));
    repeat (14) @(posedge core_clk);
    shows(SH_MAX, 16'h0320);
    repeat (40) @(posedge core_clk);
    u_front.sample(16'h00C8, 7'h00);
    u_front.push(5'h06, 60, 30);
    rdc("min", `MPM_REG_MIN, 16'h00C8);
    rdc("max", `MPM_REG_MAX, 16'h00C8);
    $display("test minmax done");
    xfer(1'b1, `MPM_REG_OFFSET_ITEM, 16'h000A);
    xfer(1'b1, `MPM_REG_SLOPE, 16'h00C8);
    u_front.sample(16'h03F2, 7'h00);
    shows(SH_MEAS, 16'h03FC);
    // enable low: a sample must not reach the display
    clkEn <= 1'b0;
    u_front.sample(16'h0000, 7'h00);
    shows(SH_MEAS, 16'h03FC);
    clkEn <= 1'b1;
    xfer(1'b1, `MPM_REG_CTRL, 16'h0000);
    xfer(1'b1, `MPM_REG_SCLO, 16'h0064);
    u_front.sample(16'h0456, 7'h00);
    shows(SH_MEAS, 16'h0460);
    u_front.sample(16'h26AC, 7'h00);
    chk("code", 16'(EC_DISP_OVER), 16'(disp.code));
    for (int i = 0; i < 7; i++) begin
      u_front.sample(16'h0456, 7'h40 >> i);
      chk("code", 16'(codes[i]), 16'(disp.code));
    end
    u_front.sample(16'h0456, 7'h00);
    chk("code", 16'(EC_NONE), 16'(disp.code));
    xfer(1'b1, `MPM_REG_CTRL, 16'h0013);
    rdc("offset_item", `MPM_REG_OFFSET_ITEM, 16'h0000);
    rdc("slope", `MPM_REG_SLOPE, 16'h0000);
    u_front.alarms(3'b100);
    chk("led", 16'h0006, 16'(led));
    u_front.alarms(3'b010);
    chk("led", 16'h0005, 16'(led));
    u_front.alarms(3'b001);
    chk("led", 16'h0007, 16'(led));
    u_front.alarms(3'b000);
    $display("test arithmetic codes done");
    xfer(1'b1, `MPM_REG_OFFSET_ITEM, 16'h270F);
    u_front.push(5'h14, 50, 20);
    chk("show", 16'(SH_ITEM_OFFSET_ITEM), 16'(disp.show));
    u_front.push(5'h02, 8, 20);
    shows(SH_EDIT, 16'h270F);
    u_front.push(5'h02, 8, 20);
    shows(SH_EDIT, 16'hF831);
    u_front.push(5'h04, 8, 20);
    shows(SH_EDIT, 16'h270F);
    u_front.push(5'h04, 8, 20);
    u_front.push(5'h01, 8, 20);
    chk("show", 16'(SH_ITEM_OFFSET_ITEM), 16'(disp.show));
    rdc("offset_item", `MPM_REG_OFFSET_ITEM, 16'h270E);
    u_front.push(5'h02, 8, 20);
    u_front.push(5'h04, 100, 20);
    chk("repeat", 16'h0001, 16'($signed(disp.value) < 9996 && $signed(disp.value) > 9980));
    u_front.push(5'h08, 8, 20);
    chk("show", 16'(SH_ITEM_OFFSET_ITEM), 16'(disp.show));
    rdc("offset_item", `MPM_REG_OFFSET_ITEM, 16'h270E);
    u_front.push(5'h02, 8, 200);
    chk("show", 16'(SH_ITEM_OFFSET_ITEM), 16'(disp.show));
    rdc("offset_item", `MPM_REG_OFFSET_ITEM, 16'h270E);
    u_front.push(5'h01, 8, 20);
    chk("show", 16'(SH_ITEM_SLOPE), 16'(disp.show));
    u_front.push(5'h01, 8, 20);
    chk("show", 16'(SH_ITEM_OFFSET_ITEM), 16'(disp.show));
    u_front.push(5'h08, 8, 20);
    xfer(1'b0, `MPM_REG_STAT, 16'h0000);
    chk("menu", 16'(MS_CLOSED), {14'h0000, rd[8:7]});
    u_front.push(5'h14, 50, 450);
    xfer(1'b0, `MPM_REG_STAT, 16'h0000);
    chk("menu", 16'(MS_CLOSED), {14'h0000, rd[8:7]});
    $display("test menu done");
    print_verdict();
  end
endmodule
